/* File: tcc_timer.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_timer
(
  // Clock, reset, freeze
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer input pins
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  // Match / capture requests
  output logic match_irq_a,
  output logic match_irq_b
);
  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] timer_count_q;
  logic [15:0] timer_count_d;
  logic [15:0] capture_compare_a_q;
  logic [15:0] capture_compare_b_q;
  logic [7:0] timer_mode_control_q;
  logic [8:0] capture_compare_control_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic irqA_q;
  logic irqB_q;
  logic oneshotPulse_q;

  // ****************************************
  // Bus decode
  // ****************************************
  logic accessPhase;
  logic wrEn;
  logic selCount;
  logic selCcA;
  logic selCcB;
  logic selMode;
  logic selCtrl;
  logic mapped;

  // Answer on the second access cycle, so read data come from a flop
  assign accessPhase = psel & penable;
  assign wrEn = accessPhase & pready_q & pwrite;
  assign selCount = (paddr == {`TCC_IDX_COUNT, 2'h0});
  assign selCcA = (paddr == {`TCC_IDX_CCA, 2'h0});
  assign selCcB = (paddr == {`TCC_IDX_CCB, 2'h0});
  assign selMode = (paddr == {`TCC_IDX_MODE, 2'h0});
  assign selCtrl = (paddr == {`TCC_IDX_CTRL, 2'h0});
  assign mapped = selCount | selCcA | selCcB | selMode | selCtrl;

  // ****************************************
  // Mode decode
  // ****************************************
  tcc_pkg::tcc_run_t runMode;
  logic running;
  logic oneshotMode;
  logic capA;
  logic capB;
  logic trigARev;

  assign runMode = tcc_pkg::tcc_run_t'(
    timer_mode_control_q[`TCC_MODE_RUN_HI:`TCC_MODE_RUN_LO]);
  assign running = (runMode != tcc_pkg::TCC_RUN_STOP);
  assign oneshotMode = timer_mode_control_q[`TCC_MODE_ONESHOT];
  assign capA = capture_compare_control_q[`TCC_CTRL_CAPA];
  assign capB = capture_compare_control_q[`TCC_CTRL_CAPB];
  assign trigARev = capture_compare_control_q[`TCC_CTRL_TRIGA_REV];

  // ****************************************
  // Input edge detection
  // ****************************************
  tcc_edge_if edgeA ();
  tcc_edge_if edgeB ();

  assign edgeA.pin = timer_input_a;
  assign edgeA.sel = tcc_pkg::tcc_edge_t'(
    capture_compare_control_q[`TCC_CTRL_EDGEA_LO+1:`TCC_CTRL_EDGEA_LO]);
  assign edgeB.pin = timer_input_b;
  assign edgeB.sel = tcc_pkg::tcc_edge_t'(
    capture_compare_control_q[`TCC_CTRL_EDGEB_LO+1:`TCC_CTRL_EDGEB_LO]);

  tcc_edge_detect u_edge_a
  (
    .clock(clock),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .edge_io(edgeA.det)
  );

  tcc_edge_detect u_edge_b
  (
    .clock(clock),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .edge_io(edgeB.det)
  );

  // ****************************************
  // Capture, compare and clear events
  // ****************************************
  logic trigA;
  logic trigB;
  logic loadA;
  logic loadB;
  logic eqA;
  logic eqB;
  logic clearCount;
  logic stopWrite;

  // Reverse input-a edge or input-b edge selects the capture for a
  assign trigA = trigARev ? edgeA.reverseEdge : edgeB.validEdge;
  assign trigB = edgeA.validEdge;
  // Compare-mode registers never load; captures only while counting
  assign loadA = running & capA & trigA;
  assign loadB = running & capB & trigB;
  assign eqA = running & (timer_count_q == capture_compare_a_q);
  assign eqB = running & (timer_count_q == capture_compare_b_q);
  // A write that clears the run bits; racing captures may be lost
  assign stopWrite = wrEn & selMode
    & (pwdata[`TCC_MODE_RUN_HI:`TCC_MODE_RUN_LO] == 2'h0);
  // Clear-and-start conditions
  assign clearCount =
    ((runMode == tcc_pkg::TCC_RUN_CLR_INPUT) & edgeA.validEdge)
    | ((runMode == tcc_pkg::TCC_RUN_CLR_MATCH) & eqA)
    | (oneshotMode & (oneshotPulse_q | edgeA.validEdge));

  // ****************************************
  // Up-counter
  // ****************************************
  // Plain 16-bit add wraps from maximum to zero on its own
  always_comb
  begin
    if (!running)
      timer_count_d = 16'h0000;
    else if (clearCount)
      timer_count_d = 16'h0000;
    else
      timer_count_d = timer_count_q + 16'h0001;
  end

  // Counter flop; no bus access touches it
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      timer_count_q <= 16'h0000;
    else if (clockEnable)
      timer_count_q <= timer_count_d;
  end

  // ****************************************
  // Capture/compare registers
  // ****************************************
  // Bus write outranks a capture in the same cycle; captured
  // value stays until reset, a write or the next capture, whatever the mode
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      capture_compare_a_q <= `TCC_CC_RESET;
      capture_compare_b_q <= `TCC_CC_RESET;
    end
    else if (clockEnable)
    begin
      if (wrEn & selCcA)
        capture_compare_a_q <= pwdata[15:0];
      else if (loadA & ~stopWrite)
        capture_compare_a_q <= timer_count_q;
      if (wrEn & selCcB)
        capture_compare_b_q <= pwdata[15:0];
      else if (loadB & ~stopWrite)
        capture_compare_b_q <= timer_count_q;
    end
  end

  // ****************************************
  // Mode and control registers
  // ****************************************
  // One-shot trigger is a write-one pulse and reads back as zero
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      timer_mode_control_q <= `TCC_MODE_RESET;
      capture_compare_control_q <= `TCC_CTRL_RESET;
      oneshotPulse_q <= 1'b0;
    end
    else if (clockEnable)
    begin
      if (wrEn & selMode)
        timer_mode_control_q <= pwdata[7:0];
      if (wrEn & selCtrl)
        capture_compare_control_q <= {1'b0, pwdata[7:0]};
      oneshotPulse_q <= wrEn & selCtrl & pwdata[`TCC_CTRL_OSTRIG];
    end
  end

  // ****************************************
  // Match requests
  // ****************************************
  // Equality pulses; input-b edge also requests a in capture mode
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      irqA_q <= 1'b0;
      irqB_q <= 1'b0;
    end
    else if (clockEnable)
    begin
      irqA_q <= (~capA & eqA) | (capA & running & edgeB.validEdge);
      irqB_q <= (~capB & eqB) | loadB;
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  // Read mux; count reads zero while stopped, read has no side effect
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    if (selCount)
      prdata_d = {16'h0000, running ? timer_count_q : 16'h0000};
    else if (selCcA)
      prdata_d = {16'h0000, capture_compare_a_q};
    else if (selCcB)
      prdata_d = {16'h0000, capture_compare_b_q};
    else if (selMode)
      prdata_d = {24'h000000, timer_mode_control_q};
    else if (selCtrl)
      prdata_d = {23'h000000, capture_compare_control_q};
  end

  // pready rises on the second access cycle and drops after
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (clockEnable)
    begin
      pready_q <= accessPhase & ~pready_q;
      pslverr_q <= accessPhase & ~pready_q & ~mapped;
      if (accessPhase & ~pready_q & ~pwrite)
        prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign match_irq_a = irqA_q;
  assign match_irq_b = irqB_q;

  // ****************************************
  // Checks
  // ****************************************
  AST_STOP_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & !running |=> timer_count_q == 16'h0000)
    else $error("count not zero while stopped");
  AST_COUNT_UP: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & running & !clearCount & !stopWrite & !(wrEn & selMode)
    |=> timer_count_q == $past(timer_count_q) + 16'h0001)
    else $error("counter did not advance");
  AST_READ_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & accessPhase & !pready_q & !pwrite & selCount & !running
    |=> prdata == 32'h0000_0000)
    else $error("stopped count read nonzero");
  AST_CLR_INPUT: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & runMode == tcc_pkg::TCC_RUN_CLR_INPUT & edgeA.validEdge
    |=> timer_count_q == 16'h0000)
    else $error("input edge did not clear count");
  AST_CLR_MATCH: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & runMode == tcc_pkg::TCC_RUN_CLR_MATCH & eqA
    |=> timer_count_q == 16'h0000)
    else $error("match did not clear count");
  AST_ONESHOT: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & oneshotMode & running & oneshotPulse_q
    |=> timer_count_q == 16'h0000)
    else $error("one-shot trigger did not clear count");
  AST_READ_PURE: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & accessPhase & !pwrite & !loadB
    |=> capture_compare_b_q == $past(capture_compare_b_q))
    else $error("read changed register b");
  AST_HOLD_A: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & !(wrEn & selCcA) & !loadA
    |=> capture_compare_a_q == $past(capture_compare_a_q))
    else $error("register a changed without cause");
  AST_NO_CAP_CMP: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & !capB & !(wrEn & selCcB)
    |=> $stable(capture_compare_b_q))
    else $error("compare register loaded");
  AST_CAP_A: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & loadA & !stopWrite & !(wrEn & selCcA)
    |=> capture_compare_a_q == $past(timer_count_q))
    else $error("capture a wrong value");
  AST_CAP_B: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & loadB & !stopWrite & !(wrEn & selCcB)
    |=> capture_compare_b_q == $past(timer_count_q) && match_irq_b)
    else $error("capture b wrong or no request");
  AST_MATCH_A: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & !capA & eqA |=> match_irq_a)
    else $error("no match a request");
  AST_MATCH_B: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & !capB & eqB |=> match_irq_b)
    else $error("no match b request");
  AST_WRAP: assert property (@(posedge clock) disable iff (!reset_n)
    clockEnable & running & !clearCount & !(wrEn & selMode)
    & timer_count_q == 16'hffff |=> timer_count_q == 16'h0000)
    else $error("counter did not wrap");
  AST_RESET_CC: assert property (@(posedge clock)
    !reset_n |=> capture_compare_a_q == 16'h0000
    && capture_compare_b_q == 16'h0000)
    else $error("reset did not clear registers");

  COV_CAP_A: cover property (@(posedge clock) disable iff (!reset_n)
    clockEnable & loadA);
  COV_MATCH_CLR: cover property (@(posedge clock) disable iff (!reset_n)
    clockEnable & runMode == tcc_pkg::TCC_RUN_CLR_MATCH & eqA);
  COV_WRAP: cover property (@(posedge clock) disable iff (!reset_n)
    clockEnable & running & timer_count_q == 16'hffff);
  COV_ONESHOT: cover property (@(posedge clock) disable iff (!reset_n)
    clockEnable & oneshotMode & oneshotPulse_q);
endmodule

/* File: tcc_consts.svh */
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register indices; byte address is four times the index
`define TCC_IDX_COUNT 16'hff10
`define TCC_IDX_CCA 16'hff12
`define TCC_IDX_CCB 16'hff14
`define TCC_IDX_MODE 16'hffba
`define TCC_IDX_CTRL 16'hff16

// Mode register fields
`define TCC_MODE_RUN_HI 3
`define TCC_MODE_RUN_LO 2
`define TCC_MODE_ONESHOT 0
`define TCC_MODE_RESET 8'h00

// Control register fields
`define TCC_CTRL_CAPA 0
`define TCC_CTRL_CAPB 1
`define TCC_CTRL_TRIGA_REV 2
`define TCC_CTRL_EDGEA_LO 4
`define TCC_CTRL_EDGEB_LO 6
`define TCC_CTRL_OSTRIG 8
`define TCC_CTRL_RESET 9'h000

`define TCC_CC_RESET 16'h0000
`endif

/* File: tcc_pkg.sv */
package tcc_pkg;
  // Run-mode bit pair settings
  typedef enum logic [1:0] {
    TCC_RUN_STOP = 2'h0,
    TCC_RUN_FREE = 2'h1,
    TCC_RUN_CLR_INPUT = 2'h2,
    TCC_RUN_CLR_MATCH = 2'h3
  } tcc_run_t;
  // Valid edge selection of an input pin
  typedef enum logic [1:0] {
    TCC_EDGE_FALL = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_NONE = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_t;
endpackage

/* File: tcc_edge_if.sv */
`timescale 1ns/1ps
interface tcc_edge_if;
  logic pin;
  tcc_pkg::tcc_edge_t sel;
  logic validEdge;
  logic reverseEdge;
  modport det (input pin, input sel, output validEdge, output reverseEdge);
  modport use_side (output pin, output sel, input validEdge, input reverseEdge);
endinterface

/* File: tcc_edge_detect.sv */
`timescale 1ns/1ps
module tcc_edge_detect
(
  // Clock and control
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // Pin and edge events
  tcc_edge_if.det edge_io
);
  logic syncA_q;
  logic syncB_q;
  logic prev_q;
  logic rise;
  logic fall;

  // Two-stage synchroniser, then one stage for edge history
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else if (clockEnable)
    begin
      syncA_q <= edge_io.pin;
      syncB_q <= syncA_q;
      prev_q <= syncB_q;
    end
  end

  // Edge decode; reverse phase is impossible when both edges count
  assign rise = syncB_q & ~prev_q;
  assign fall = ~syncB_q & prev_q;
  assign edge_io.validEdge = clockEnable & (
    (edge_io.sel == tcc_pkg::TCC_EDGE_RISE) ? rise :
    (edge_io.sel == tcc_pkg::TCC_EDGE_FALL) ? fall :
    (edge_io.sel == tcc_pkg::TCC_EDGE_BOTH) ? (rise | fall) : 1'b0);
  assign edge_io.reverseEdge = clockEnable & (
    (edge_io.sel == tcc_pkg::TCC_EDGE_RISE) ? fall :
    (edge_io.sel == tcc_pkg::TCC_EDGE_FALL) ? rise : 1'b0);
endmodule

/* File: tcc_pin_source.sv */
`timescale 1ns/1ps
// ****************************************
// Pin source model
// ****************************************
module tcc_pin_source
(
  // Clock
  input wire logic clock,
  // Driven timer pins
  output logic pinA,
  output logic pinB
);
  // Sources idle low and hold their last level between events
  initial
  begin
    pinA = 1'b0;
    pinB = 1'b0;
  end
  // One level change; the hold after it keeps edges distinct
  task automatic toggle(input logic which, input logic lvl);
    @(posedge clock);
    if (which)
      pinB <= lvl;
    else
      pinA <= lvl;
    repeat (4) @(posedge clock);
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "tcc_consts.svh"
// ****************************************
// Timer block testbench
// ****************************************
module tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clockEnable = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic matchA;
  logic matchB;
  logic pinA;
  logic pinB;
  logic pinAPrev = 1'b0;
  logic [31:0] v;
  logic [31:0] w;
  logic [31:0] x;
  logic e;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int nA = 0;
  int nB = 0;
  int lastA = 0;
  int gapA = 0;
  int lastB = 0;
  int gapB = 0;
  int lastPin = 0;
  int gapPin = 0;
  int n0;

  tcc_timer u_tcc_timer (.clock(clock), .reset_n(reset_n), .clockEnable(clockEnable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_a(pinA),
    .timer_input_b(pinB), .match_irq_a(matchA), .match_irq_b(matchB));
  tcc_pin_source u_tcc_pin_source (.clock(clock), .pinA(pinA), .pinB(pinB));

  // Clock, 100 ns period
  always #50 clock = ~clock;

  // Event monitor and hang guard; gaps are in clock cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (matchA === 1'b1)
    begin
      nA <= nA + 1;
      gapA <= cyc - lastA;
      lastA <= cyc;
    end
    if (matchB === 1'b1)
    begin
      nB <= nB + 1;
      gapB <= cyc - lastB;
      lastB <= cyc;
    end
    if (pinA !== pinAPrev)
    begin
      gapPin <= cyc - lastPin;
      lastPin <= cyc;
    end
    pinAPrev <= pinA;
    if (cyc == 90000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One whole-word transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic r;
    apb(1'b1, idx, wd, d, r);
  endtask

  task automatic rreg(input logic [15:0] idx, output logic [31:0] rd);
    logic r;
    apb(1'b0, idx, 32'h0, rd, r);
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rreg(`TCC_IDX_COUNT, v);
    chk("count reset", v, 32'h0);
    rreg(`TCC_IDX_CCA, v);
    chk("cca reset", v, 32'h0);
    rreg(`TCC_IDX_CCB, v);
    chk("ccb reset", v, 32'h0);
    apb(1'b0, 16'h0001, 32'h0, v, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    $display("test reset done");
    // Back-to-back reads are four cycles apart
    wreg(`TCC_IDX_MODE, 32'h4);
    rreg(`TCC_IDX_COUNT, v);
    rreg(`TCC_IDX_COUNT, w);
    chk("count step", w - v, 32'h4);
    // Freeze 20 cycles between two reads: the step must not grow
    rreg(`TCC_IDX_COUNT, v);
    clockEnable <= 1'b0;
    repeat (20) @(posedge clock);
    clockEnable <= 1'b1;
    rreg(`TCC_IDX_COUNT, w);
    chk("count frozen", w - v, 32'h4);
    rreg(`TCC_IDX_CCB, v);
    chk("ccb after count read", v, 32'h0);
    wreg(`TCC_IDX_MODE, 32'h0);
    rreg(`TCC_IDX_COUNT, v);
    chk("count stopped", v, 32'h0);
    $display("test run stop done");
    // Compares only written while stopped
    wreg(`TCC_IDX_CCA, 32'h9);
    wreg(`TCC_IDX_CCB, 32'h3);
    wreg(`TCC_IDX_MODE, 32'hc);
    repeat (40) @(posedge clock);
    chk("match a period", 32'(gapA), 32'ha);
    chk("match b period", 32'(gapB), 32'ha);
    wreg(`TCC_IDX_MODE, 32'h0);
    $display("test clear on match done");
    // Full wrap: two matches one count period apart
    wreg(`TCC_IDX_CCA, 32'h5);
    n0 = nA;
    wreg(`TCC_IDX_MODE, 32'h4);
    repeat (66000) @(posedge clock);
    chk("wrap matches", 32'(nA - n0), 32'h2);
    chk("wrap period", 32'(gapA), 32'h10000);
    wreg(`TCC_IDX_MODE, 32'h0);
    $display("test wrap done");
    // Register b captures on both edges of input a
    wreg(`TCC_IDX_CTRL, 32'h32);
    wreg(`TCC_IDX_MODE, 32'h4);
    n0 = nB;
    u_tcc_pin_source.toggle(1'b0, 1'b1);
    rreg(`TCC_IDX_CCB, v);
    u_tcc_pin_source.toggle(1'b0, 1'b0);
    rreg(`TCC_IDX_CCB, w);
    chk("ccb capture gap", w - v, 32'(gapPin));
    chk("ccb capture irqs", 32'(nB - n0), 32'h2);
    rreg(`TCC_IDX_COUNT, x);
    rreg(`TCC_IDX_CCB, x);
    chk("ccb held", x, w);
    $display("test capture b done");
    // Register a captures on input b; b in compare ignores input a
    wreg(`TCC_IDX_MODE, 32'h0);
    wreg(`TCC_IDX_CTRL, 32'h71);
    wreg(`TCC_IDX_MODE, 32'h4);
    rreg(`TCC_IDX_CCB, w);
    u_tcc_pin_source.toggle(1'b1, 1'b1);
    u_tcc_pin_source.toggle(1'b0, 1'b1);
    rreg(`TCC_IDX_CCA, v);
    chk("cca captured", {31'h0, v != 32'h5}, 32'h1);
    rreg(`TCC_IDX_CCB, x);
    chk("ccb no capture", x, w);
    wreg(`TCC_IDX_MODE, 32'h0);
    wreg(`TCC_IDX_CTRL, 32'h15);
    rreg(`TCC_IDX_CCA, x);
    chk("cca kept", x, v);
    wreg(`TCC_IDX_MODE, 32'h4);
    u_tcc_pin_source.toggle(1'b0, 1'b0);
    rreg(`TCC_IDX_CCA, w);
    chk("cca reverse edge", {31'h0, w != v}, 32'h1);
    u_tcc_pin_source.toggle(1'b0, 1'b1);
    rreg(`TCC_IDX_CCA, x);
    chk("cca valid edge ignored", x, w);
    $display("test capture a done");
    // Clear and start on input a
    wreg(`TCC_IDX_MODE, 32'h0);
    wreg(`TCC_IDX_CTRL, 32'h10);
    wreg(`TCC_IDX_CCA, 32'hffff);
    u_tcc_pin_source.toggle(1'b0, 1'b0);
    wreg(`TCC_IDX_MODE, 32'h8);
    repeat (100) @(posedge clock);
    u_tcc_pin_source.toggle(1'b0, 1'b1);
    rreg(`TCC_IDX_COUNT, v);
    chk("count cleared by edge", {31'h0, v < 32'h14}, 32'h1);
    $display("test clear on input done");
    // One-shot: software trigger, then input edge
    wreg(`TCC_IDX_MODE, 32'h0);
    wreg(`TCC_IDX_MODE, 32'h5);
    repeat (100) @(posedge clock);
    wreg(`TCC_IDX_CTRL, 32'h110);
    rreg(`TCC_IDX_COUNT, v);
    chk("count cleared by trigger", {31'h0, v < 32'h14}, 32'h1);
    repeat (100) @(posedge clock);
    u_tcc_pin_source.toggle(1'b0, 1'b0);
    u_tcc_pin_source.toggle(1'b0, 1'b1);
    rreg(`TCC_IDX_COUNT, v);
    chk("one-shot edge clear", {31'h0, v < 32'h14}, 32'h1);
    $display("test one-shot done");
    // Mid-run reset while running with nonzero registers
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    rreg(`TCC_IDX_CCA, v);
    chk("cca after reset", v, 32'h0);
    rreg(`TCC_IDX_CCB, v);
    chk("ccb after reset", v, 32'h0);
    rreg(`TCC_IDX_COUNT, v);
    chk("count after reset", v, 32'h0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
